// ### flash_prog_cfg.svh
/*
 * Constants for the flash programming and tap select block: instruction
 * codes, page geometry, pad count and timing counts.
 * Assumes a 100 MHz system clock.
 */
`ifndef FLASH_PROG_CFG_SVH
`define FLASH_PROG_CFG_SVH

// ==========================================================
// instruction register of the shared test port
`define IR_LEN 8
`define IR_CAPTURE 8'h01
`define INSTR_PICK_FABRIC 8'h3c
`define INSTR_PICK_DEBUG 8'h3d

// ==========================================================
// nonvolatile memory pages
`define PAGE_BYTES 132
`define NVM_PAGES 64
`define NVM_PAGE_BITS 6

// ==========================================================
// fabric pads
`define IO_WIDTH 16

// ==========================================================
// timing
`define MCLK_MHZ 100
`define PAGE_PROG_TIME_MS 8
`define PAGE_PROG_CYCLES (`PAGE_PROG_TIME_MS * 1000 * `MCLK_MHZ)
`define PROG_CNT_W 20
`define SUBSYS_RESET_TIME_NS 160
`define SUBSYS_RESET_CYCLES \
    ((`SUBSYS_RESET_TIME_NS * `MCLK_MHZ + 999) / 1000)
`define RST_CNT_W 5

`endif

// ### flash_prog_pkg.sv
/*
 * Types for the flash programming and tap select block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package flash_prog_pkg;

    // ==========================================================
    // test port controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR,
        TAP_EX1_DR, TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
        TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
    } tap_state_t;

    // ==========================================================
    // page commands and pad parking modes
    typedef enum logic [1:0] {
        NVM_PROTECT, NVM_UNPROTECT, NVM_ERASE, NVM_PROGRAM
    } nvm_op_t;

    typedef enum logic [1:0] {
        PARK_TRISTATE, PARK_HOLD, PARK_PRESET
    } park_mode_t;

endpackage : flash_prog_pkg

`default_nettype wire

// ### flash_prog_tap_select.sv
/*
 * Flash programming support: test port target selection, debug reset
 * hold, fabric pad parking, subsystem reset after in-application
 * reprogramming of the fabric, and page protection and timing of the
 * nonvolatile memory.
 * Assumes tck and the test port pins come from an external probe, and
 * that the remaining inputs are synchronous to mclk.
 */
// Behaviour
// - fabric selected: route fabric, hold debug reset
// - selection picks exactly one test target
// - instruction picks target, pin ignored until tap reset
// - park fabric pads while fabric programs
// - reset subsystem after in-application fabric reprogram
// - protected page refuses erase and program
// - one page program takes 8 ms
`include "flash_prog_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_prog_tap_select #(
    parameter int PAGE_PROG_CYCLES = `PAGE_PROG_CYCLES
) (
    // system clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // test port pins
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic tap_target_select,
    // test targets
    output logic fabric_tms,
    input wire logic fabric_tdo,
    input wire logic fabric_tdo_oe,
    output logic debug_tms,
    input wire logic debug_tdo,
    input wire logic debug_tdo_oe,
    output logic debug_test_reset_n,
    output logic fabric_selected,
    // fabric programming and pads
    input wire logic fabric_programming,
    input wire logic in_application_active,
    input wire flash_prog_pkg::park_mode_t park_mode,
    input wire logic [`IO_WIDTH-1:0] user_io_out,
    input wire logic [`IO_WIDTH-1:0] user_io_oe,
    input wire logic [`IO_WIDTH-1:0] preset_io_out,
    input wire logic [`IO_WIDTH-1:0] preset_io_oe,
    output logic [`IO_WIDTH-1:0] pad_out,
    output logic [`IO_WIDTH-1:0] pad_oe,
    output logic io_parked,
    output logic subsystem_reset_n,
    // page commands
    input wire logic nvm_cmd_valid,
    output logic nvm_cmd_ready,
    input wire flash_prog_pkg::nvm_op_t nvm_cmd_op,
    input wire logic [`NVM_PAGE_BITS-1:0] nvm_cmd_page,
    output logic nvm_busy,
    output logic [`NVM_PAGE_BITS-1:0] nvm_page,
    output logic nvm_erase,
    output logic nvm_done,
    output logic nvm_refused
);
    import flash_prog_pkg::*;

    localparam logic [`PROG_CNT_W-1:0] PROG_LAST =
        `PROG_CNT_W'(PAGE_PROG_CYCLES - 1);
    localparam logic [`RST_CNT_W-1:0] RST_LEN =
        `RST_CNT_W'(`SUBSYS_RESET_CYCLES);

    // ==========================================================
    // test port controller, tck domain
    function automatic tap_state_t tap_next(tap_state_t s, logic m);
        case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EX2_DR : TAP_PAUSE_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EX2_IR : TAP_PAUSE_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    endfunction : tap_next

    tap_state_t tap_state;
    logic [`IR_LEN-1:0] ir_shift;
    logic pick_valid;
    logic pick_fabric;
    logic fabric_sel;

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tap_state <= TAP_RESET;
        end else begin
            tap_state <= tap_next(tap_state, tms);
        end
    end

    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            ir_shift <= '0;
        end else if (tap_state == TAP_CAP_IR) begin
            ir_shift <= `IR_CAPTURE;
        end else if (tap_state == TAP_SH_IR) begin
            ir_shift <= {tdi, ir_shift[`IR_LEN-1:1]};
        end
    end

    // instruction override of the selection pin
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            pick_valid <= 1'b0;
            pick_fabric <= 1'b0;
        end else if (tap_state == TAP_RESET) begin
            pick_valid <= 1'b0;
        end else if (tap_state == TAP_UPD_IR) begin
            if (ir_shift == `INSTR_PICK_FABRIC) begin
                pick_valid <= 1'b1;
                pick_fabric <= 1'b1;
            end else if (ir_shift == `INSTR_PICK_DEBUG) begin
                pick_valid <= 1'b1;
                pick_fabric <= 1'b0;
            end
        end
    end

    // ==========================================================
    // target routing and debug reset hold
    // board is expected to tie the pin high
    assign fabric_sel = pick_valid ? pick_fabric : tap_target_select;
    assign debug_test_reset_n = trst_n & ~fabric_sel;
    assign fabric_tms = fabric_sel ? tms : 1'b1;
    assign debug_tms = fabric_sel ? 1'b1 : tms;
    assign tdo = fabric_sel ? fabric_tdo : debug_tdo;
    assign tdo_oe = fabric_sel ? fabric_tdo_oe : debug_tdo_oe;

    // ==========================================================
    // selection status into mclk domain
    logic sel_meta;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sel_meta <= 1'b0;
            fabric_selected <= 1'b0;
        end else begin
            sel_meta <= fabric_sel;
            fabric_selected <= sel_meta;
        end
    end

    // ==========================================================
    // fabric pad parking
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pad_out <= '0;
            pad_oe <= '0;
            io_parked <= 1'b0;
        end else begin
            io_parked <= fabric_programming;
            if (!fabric_programming) begin
                pad_out <= user_io_out;
                pad_oe <= user_io_oe;
            end else if (park_mode == PARK_PRESET) begin
                pad_out <= preset_io_out;
                pad_oe <= preset_io_oe;
            end else if (park_mode != PARK_HOLD) begin
                pad_oe <= '0;
            end
        end
    end

    // ==========================================================
    // subsystem reset after in-application fabric reprogram
    logic prog_q;
    logic [`RST_CNT_W-1:0] rst_cnt;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prog_q <= 1'b0;
            rst_cnt <= '0;
            subsystem_reset_n <= 1'b1;
        end else begin
            prog_q <= fabric_programming;
            if (prog_q && !fabric_programming && in_application_active)
            begin
                rst_cnt <= RST_LEN;
                subsystem_reset_n <= 1'b0;
            end else if (rst_cnt != '0) begin
                rst_cnt <= rst_cnt - 1'b1;
                subsystem_reset_n <= (rst_cnt == 1);
            end
        end
    end

    // ==========================================================
    // page protection and page program timing
    logic [`NVM_PAGES-1:0] page_protect;
    logic [`PROG_CNT_W-1:0] prog_cnt;
    logic cmd_take;
    logic page_locked;

    assign nvm_cmd_ready = !nvm_busy;
    assign cmd_take = nvm_cmd_valid && nvm_cmd_ready;
    assign page_locked = page_protect[nvm_cmd_page];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            page_protect <= '0;
        end else if (cmd_take && nvm_cmd_op == NVM_PROTECT) begin
            page_protect[nvm_cmd_page] <= 1'b1;
        end else if (cmd_take && nvm_cmd_op == NVM_UNPROTECT) begin
            page_protect[nvm_cmd_page] <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nvm_busy <= 1'b0;
            nvm_page <= '0;
            nvm_erase <= 1'b0;
            prog_cnt <= '0;
            nvm_done <= 1'b0;
            nvm_refused <= 1'b0;
        end else begin
            nvm_done <= 1'b0;
            nvm_refused <= 1'b0;
            if (cmd_take) begin
                if (nvm_cmd_op == NVM_PROTECT ||
                    nvm_cmd_op == NVM_UNPROTECT) begin
                    nvm_done <= 1'b1;
                end else if (page_locked) begin
                    nvm_refused <= 1'b1;
                end else begin
                    nvm_busy <= 1'b1;
                    nvm_page <= nvm_cmd_page;
                    nvm_erase <= (nvm_cmd_op == NVM_ERASE);
                    prog_cnt <= PROG_LAST;
                end
            end else if (nvm_busy) begin
                if (prog_cnt == '0) begin
                    nvm_busy <= 1'b0;
                    nvm_done <= 1'b1;
                end else begin
                    prog_cnt <= prog_cnt - 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // checks
    a_debug_reset_hold: assert property (
        @(posedge mclk) disable iff (!arst_n)
        fabric_sel |-> !debug_test_reset_n && fabric_tms == tms)
        else $error("debug reset not held with fabric selected");

    a_one_target: assert property (
        @(posedge tck) disable iff (!trst_n)
        (fabric_sel ? debug_tms : fabric_tms) &&
        tdo == (fabric_sel ? fabric_tdo : debug_tdo))
        else $error("test port reaches the wrong target");

    a_pick_instr: assert property (
        @(posedge tck) disable iff (!trst_n)
        tap_state == TAP_UPD_IR && ir_shift == `INSTR_PICK_FABRIC
        ##1 tap_state != TAP_RESET |-> fabric_sel && !debug_test_reset_n)
        else $error("pick instruction did not select fabric");

    a_reset_comb: assert property (
        @(posedge mclk) disable iff (!arst_n)
        !trst_n |-> !debug_test_reset_n)
        else $error("debug reset released while pin reset low");

    a_pads_parked: assert property (
        @(posedge mclk) disable iff (!arst_n)
        fabric_programming && park_mode == PARK_TRISTATE
        |=> pad_oe == '0 && io_parked)
        else $error("fabric pads driven while programming");

    a_pads_hold: assert property (
        @(posedge mclk) disable iff (!arst_n)
        fabric_programming && park_mode == PARK_HOLD
        |=> $stable(pad_out) && $stable(pad_oe))
        else $error("held pads changed while programming");

    a_subsys_reset: assert property (
        @(posedge mclk) disable iff (!arst_n)
        prog_q && !fabric_programming && in_application_active
        |=> !subsystem_reset_n [*8])
        else $error("subsystem not reset after fabric reprogram");

    a_locked_refuse: assert property (
        @(posedge mclk) disable iff (!arst_n)
        cmd_take && page_locked &&
        (nvm_cmd_op == NVM_ERASE || nvm_cmd_op == NVM_PROGRAM)
        |=> nvm_refused && !nvm_busy)
        else $error("protected page accepted erase or program");

    a_prog_count: assert property (
        @(posedge mclk) disable iff (!arst_n)
        nvm_busy && !cmd_take && prog_cnt != '0
        |=> nvm_busy && prog_cnt == $past(prog_cnt) - 1'b1)
        else $error("page program ended early");

    a_prog_start: assert property (
        @(posedge mclk) disable iff (!arst_n)
        $rose(nvm_busy) |-> prog_cnt == PROG_LAST)
        else $error("page program timer not loaded");

    c_pick_fabric: cover property (
        @(posedge tck) disable iff (!trst_n)
        pick_valid && pick_fabric && !tap_target_select);

    c_refused: cover property (
        @(posedge mclk) disable iff (!arst_n) nvm_refused);

    c_subsys_reset: cover property (
        @(posedge mclk) disable iff (!arst_n) $fell(subsystem_reset_n));

    c_prog_done: cover property (
        @(posedge mclk) disable iff (!arst_n) nvm_busy ##1 nvm_done);

endmodule : flash_prog_tap_select

`default_nettype wire

// ### jtag_probe.sv
/* partner model: external probe on the shared test port.
   assumes the device samples tms and tdi on the rising tck edge. */
`timescale 1ns/1ps
`default_nettype none

module jtag_probe (
    // test port pins
    output logic tck,
    output logic trst_n,
    output logic tms,
    output logic tdi
);
    // ===========================================================
    // pins idle; tck stands still outside frames
    initial begin
        tck = 1'b0;
        trst_n = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // ===========================================================
    // frame tasks, tck period 125 ns
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #62.5 tck = 1'b1;
        #62.5 tck = 1'b0;
    endtask : step

    task automatic pick(input logic [7:0] code);
        logic [4:0] pre;
        pre = 5'b00110;
        for (int i = 0; i < 5; i++) begin
            step(pre[i], 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            step(i == 7, code[i]);
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        // one idle clock so the new target is seen by the tap side
        step(1'b0, 1'b0);
        tdi = ~tdi;
    endtask : pick

    task automatic set_tms(input logic m);
        tms = m;
    endtask : set_tms

    task automatic hold_reset(input logic v);
        trst_n = v;
    endtask : hold_reset
endmodule : jtag_probe

`default_nettype wire

// ### flash_programming_tap_select_tb.sv
/* testbench for the flash programming and tap select block.
   assumes the probe model jtag_probe and a 100 MHz mclk. */
`include "flash_prog_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_programming_tap_select_tb;
    import flash_prog_pkg::*;
    localparam int PPC = 20;
    logic mclk, arst_n, tck, trst_n, tms, tdi, tdo, tdo_oe;
    logic tap_target_select, fabric_tms, fabric_tdo, fabric_tdo_oe;
    logic debug_tms, debug_tdo, debug_tdo_oe, debug_test_reset_n;
    logic fabric_selected, fabric_programming, in_application_active;
    park_mode_t park_mode;
    logic [`IO_WIDTH-1:0] user_io_out, user_io_oe, pad_out, pad_oe;
    logic [`IO_WIDTH-1:0] preset_io_out, preset_io_oe;
    logic io_parked, subsystem_reset_n, nvm_cmd_valid, nvm_cmd_ready;
    nvm_op_t nvm_cmd_op;
    logic [5:0] nvm_cmd_page, nvm_page, pg;
    logic nvm_busy, nvm_erase, nvm_done, nvm_refused;
    logic [31:0] exp_pad;
    int err_count = 0;
    int num_checks = 0;
    int low;

    flash_prog_tap_select #(
        .PAGE_PROG_CYCLES(PPC)
    ) u_flash_prog_tap_select (
        .mclk(mclk), .arst_n(arst_n), .tck(tck), .trst_n(trst_n),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .tap_target_select(tap_target_select),
        .fabric_tms(fabric_tms), .fabric_tdo(fabric_tdo),
        .fabric_tdo_oe(fabric_tdo_oe), .debug_tms(debug_tms),
        .debug_tdo(debug_tdo), .debug_tdo_oe(debug_tdo_oe),
        .debug_test_reset_n(debug_test_reset_n),
        .fabric_selected(fabric_selected),
        .fabric_programming(fabric_programming),
        .in_application_active(in_application_active),
        .park_mode(park_mode), .user_io_out(user_io_out),
        .user_io_oe(user_io_oe), .preset_io_out(preset_io_out),
        .preset_io_oe(preset_io_oe), .pad_out(pad_out), .pad_oe(pad_oe),
        .io_parked(io_parked), .subsystem_reset_n(subsystem_reset_n),
        .nvm_cmd_valid(nvm_cmd_valid), .nvm_cmd_ready(nvm_cmd_ready),
        .nvm_cmd_op(nvm_cmd_op), .nvm_cmd_page(nvm_cmd_page),
        .nvm_busy(nvm_busy), .nvm_page(nvm_page), .nvm_erase(nvm_erase),
        .nvm_done(nvm_done), .nvm_refused(nvm_refused)
    );
    jtag_probe u_jtag_probe (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi));

    // ===========================================================
    // checking helpers
    task automatic chk(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task automatic test_done;
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    // pads while parked: preset, hold, or tristate with pad_out kept
    function automatic logic [31:0] exp_pads(input int m,
                                             input logic [31:0] usr, pre);
        exp_pads = (m == PARK_PRESET) ? pre : usr;
        if (m != PARK_HOLD && m != PARK_PRESET) begin
            exp_pads[15:0] = '0;
        end
    endfunction : exp_pads

    task automatic route_chk(input logic f);
        logic [1:0] t;
        #1;
        t = f ? {fabric_tdo_oe, fabric_tdo} : {debug_tdo_oe, debug_tdo};
        chk("fabric_tms", f ? tms : 1'b1, fabric_tms);
        chk("debug_tms", f ? 1'b1 : tms, debug_tms);
        chk("tdo", t, {tdo_oe, tdo});
        chk("debug_rst", trst_n & ~f, debug_test_reset_n);
        repeat (3) @(negedge mclk);
        chk("fabric_selected", f, fabric_selected);
    endtask : route_chk

    task automatic cmd(input nvm_op_t op, input logic [5:0] p,
                       input logic [1:0] res, input int blen);
        int bn, dn, rn;
        logic ok;
        bn = 0;
        dn = 0;
        rn = 0;
        ok = 1'b1;
        @(negedge mclk);
        nvm_cmd_valid = 1'b1;
        nvm_cmd_op = op;
        nvm_cmd_page = p;
        for (int k = 0; nvm_cmd_ready !== 1'b1; k++) begin
            if (k > 50) begin
                err_count++;
                test_done();
            end
            @(negedge mclk);
        end
        @(negedge mclk);
        nvm_cmd_valid = 1'b0;
        for (int k = 0; k < PPC + 10; k++) begin
            bn += int'(nvm_busy !== 1'b0);
            dn += int'(nvm_done !== 1'b0);
            rn += int'(nvm_refused !== 1'b0);
            if (nvm_busy) begin
                ok &= nvm_page === p && nvm_erase === (op == NVM_ERASE);
            end
            @(negedge mclk);
        end
        chk("busy_len", blen, bn);
        chk("done_n", res[0], dn);
        chk("refused_n", res[1], rn);
        chk("busy_fields", 1'b1, ok);
    endtask : cmd

    // ===========================================================
    // clock, watchdog and main sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        test_done();
    end

    initial begin
        void'($urandom(32'h51492581));
        arst_n = 1'b0;
        tap_target_select = 1'b1;
        {fabric_tdo, fabric_tdo_oe, debug_tdo, debug_tdo_oe} = 4'h0;
        fabric_programming = 1'b0;
        in_application_active = 1'b0;
        park_mode = PARK_TRISTATE;
        {user_io_out, user_io_oe, preset_io_out, preset_io_oe} = '0;
        nvm_cmd_valid = 1'b0;
        nvm_cmd_op = NVM_PROTECT;
        nvm_cmd_page = 6'h00;
        repeat (4) @(negedge mclk);
        arst_n = 1'b1;
        u_jtag_probe.hold_reset(1'b1);
        for (int i = 0; i < 16; i++) begin
            @(negedge mclk);
            tap_target_select = 1'($urandom);
            {fabric_tdo, fabric_tdo_oe, debug_tdo, debug_tdo_oe} = 4'($urandom);
            u_jtag_probe.set_tms(1'($urandom));
            route_chk(tap_target_select);
        end
        tap_target_select = 1'b1;
        u_jtag_probe.pick(`INSTR_PICK_DEBUG);
        route_chk(1'b0);
        u_jtag_probe.pick(8'h55);
        route_chk(1'b0);
        tap_target_select = 1'b0;
        u_jtag_probe.pick(`INSTR_PICK_FABRIC);
        route_chk(1'b1);
        repeat (5) u_jtag_probe.step(1'b1, 1'b0);
        route_chk(1'b0);
        u_jtag_probe.pick(`INSTR_PICK_FABRIC);
        route_chk(1'b1);
        u_jtag_probe.hold_reset(1'b0);
        route_chk(1'b0);
        u_jtag_probe.hold_reset(1'b1);
        route_chk(1'b0);
        for (int m = 0; m < 4; m++) begin
            park_mode = park_mode_t'(m);
            {user_io_out, user_io_oe} = $urandom;
            {preset_io_out, preset_io_oe} = $urandom;
            repeat (2) @(negedge mclk);
            exp_pad = exp_pads(m, {user_io_out, user_io_oe},
                               {preset_io_out, preset_io_oe});
            fabric_programming = 1'b1;
            in_application_active = 1'(m);
            repeat (2) @(negedge mclk);
            {user_io_out, user_io_oe} = $urandom;
            repeat (2) @(negedge mclk);
            chk("pads", exp_pad, {pad_out, pad_oe});
            chk("io_parked", 1'b1, io_parked);
            fabric_programming = 1'b0;
            low = 0;
            repeat (40) begin
                @(negedge mclk);
                low += int'(subsystem_reset_n !== 1'b1);
            end
            chk("reset_len", m[0] ? `SUBSYS_RESET_CYCLES : 0, low);
        end
        pg = 6'($urandom);
        cmd(NVM_PROTECT, pg, 2'b01, 0);
        cmd(NVM_ERASE, pg, 2'b10, 0);
        cmd(NVM_PROGRAM, pg, 2'b10, 0);
        cmd(NVM_PROGRAM, pg ^ 6'h01, 2'b01, PPC);
        cmd(NVM_UNPROTECT, pg, 2'b01, 0);
        cmd(NVM_ERASE, pg, 2'b01, PPC);
        cmd(NVM_PROGRAM, 6'h3f, 2'b01, PPC);
        test_done();
    end
endmodule : flash_programming_tap_select_tb

`default_nettype wire
